// File: logic/rsa_map.svh
// Register offsets, field positions, reset values and command codes
`ifndef RSA_MAP_SVH
`define RSA_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSA_ADDR_WIDTH_SET 5'h03
`define RSA_ADDR_CHANNEL   5'h05
`define RSA_ADDR_STATUS    5'h07
`define RSA_ADDR_OBSERVE   5'h08
`define RSA_ADDR_CARRIER   5'h09
`define RSA_ADDR_P0        5'h0A
`define RSA_ADDR_P1        5'h0B
`define RSA_ADDR_P2        5'h0C
`define RSA_ADDR_P3        5'h0D
`define RSA_ADDR_P4        5'h0E
`define RSA_ADDR_P5        5'h0F

// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define RSA_CMD_OP_MSB     7
`define RSA_CMD_OP_LSB     5
`define RSA_CMD_OP_READ    3'h0
`define RSA_CMD_OP_WRITE   3'h1
`define RSA_CMD_ADDR_MSB   4

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define RSA_ST_RX_READY    6
`define RSA_ST_TX_SENT     5
`define RSA_ST_RT_LIMIT    4

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RSA_RST_P0         40'hE7E7E7E7E7
`define RSA_RST_P1         40'hC2C2C2C2C2
`define RSA_RST_P2         8'hC3
`define RSA_RST_P3         8'hC4
`define RSA_RST_P4         8'hC5
`define RSA_RST_P5         8'hC6
`define RSA_RST_PIPE_NO    3'h7
`define RSA_RST_WIDTH      2'h3
`define RSA_WIDTH_ILLEGAL  2'h0
`define RSA_CNT_MAX        4'hF
`define RSA_ADDR_BYTES     3'h5

`endif

// File: logic/rsa_pkg.sv
// Types shared by the register block and its serial link
package rsa_pkg;

	// ----------------------------------------
	// Register snapshot seen by the link
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  observe;
		logic [7:0]  carrier;
		logic [39:0] p0;
		logic [39:0] p1;
		logic [7:0]  p2;
		logic [7:0]  p3;
		logic [7:0]  p4;
		logic [7:0]  p5;
		logic [1:0]  width;
	} rsa_snap_t;

	// ----------------------------------------
	// Frame captured on the link clock
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  cmd;
		logic        cmd_done;
		logic [4:0]  byte_valid;
		logic [39:0] data;
	} rsa_frame_t;

	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [6:0] shift;
	} rsa_shift_t;

	// ----------------------------------------
	// Events and levels from the radio datapath
	// ----------------------------------------
	typedef struct packed {
		logic       rx_payload_arrived;
		logic [2:0] rx_pipe_index;
		logic       tx_fifo_full;
		logic       packet_sent;
		logic       ack_received;
		logic       auto_ack_enabled;
		logic       retransmit_limit_hit;
		logic       packet_lost;
		logic       packet_retransmitted;
		logic       new_packet_start;
		logic       carrier_sensed;
	} rsa_events_t;

	typedef struct packed {
		logic [5:0][39:0] pipe_addr;
		logic [1:0]       width_code;
	} rsa_addr_out_t;

	// ----------------------------------------
	// Whole state of the register block
	// ----------------------------------------
	typedef struct packed {
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_s3;
		logic        receive_ready_flag;
		logic        transmit_sent_flag;
		logic        retransmit_limit_flag;
		logic [2:0]  pipe_no;
		logic        tx_full;
		logic        carrier_detect;
		logic [3:0]  lost_packet_count;
		logic [3:0]  retransmit_count;
		logic [1:0]  width_code;
		logic [39:0] p0;
		logic [39:0] p1;
		logic [7:0]  p2;
		logic [7:0]  p3;
		logic [7:0]  p4;
		logic [7:0]  p5;
		rsa_snap_t   snap;
	} rsa_state_t;

endpackage

// File: logic/rsa_spi_link.sv
// Serial link end: shifts command and data bytes on the link clock
`include "rsa_map.svh"

module rsa_spi_link (
	input  wire logic               rst,
	input  wire logic               sck,
	input  wire logic               cs_n,
	input  wire logic               mosi,
	input  wire rsa_pkg::rsa_snap_t snap,
	output logic                    miso,
	output logic                    miso_oe,
	output rsa_pkg::rsa_frame_t     frame
);
	import rsa_pkg::*;

	rsa_shift_t sh_r;
	rsa_shift_t sh_nxt;
	rsa_frame_t fr_r;
	rsa_frame_t fr_nxt;
	logic       frame_rst;
	logic [7:0] in_byte;
	logic [7:0] out_byte;
	logic [7:0] rd_byte;
	logic [2:0] rd_idx;

	// ----------------------------------------
	// Shift counters, cleared between frames
	// ----------------------------------------
	assign frame_rst = rst | cs_n;
	assign in_byte   = {sh_r.shift, mosi};

	always_comb begin
		sh_nxt         = sh_r;
		sh_nxt.shift   = in_byte[6:0];
		sh_nxt.bit_cnt = sh_r.bit_cnt + 3'h1;
		if (sh_r.bit_cnt == 3'h7 && sh_r.byte_cnt != 3'h7) begin
			sh_nxt.byte_cnt = sh_r.byte_cnt + 3'h1;
		end
	end

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			sh_r <= '0;
		end else begin
			sh_r <= sh_nxt;
		end
	end

	// ----------------------------------------
	// Frame capture, held after the frame ends
	// ----------------------------------------
	always_comb begin
		fr_nxt = fr_r;
		rd_idx = sh_r.byte_cnt - 3'h1;
		if (sh_r.bit_cnt == 3'h0 && sh_r.byte_cnt == 3'h0) begin
			fr_nxt.cmd_done   = 1'b0;
			fr_nxt.byte_valid = '0;
		end
		if (sh_r.bit_cnt == 3'h7) begin
			case (sh_r.byte_cnt)
				3'h0: begin
					fr_nxt.cmd      = in_byte;
					fr_nxt.cmd_done = 1'b1;
				end
				3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
					fr_nxt.data[rd_idx*8 +: 8]   = in_byte;
					fr_nxt.byte_valid[rd_idx]    = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			fr_r <= '0;
		end else begin
			fr_r <= fr_nxt;
		end
	end

	assign frame = fr_r;

	// ----------------------------------------
	// Read data, status first in every frame
	// ----------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		case (fr_r.cmd[`RSA_CMD_ADDR_MSB:0])
			`RSA_ADDR_WIDTH_SET: rd_byte = {6'h00, snap.width};
			`RSA_ADDR_STATUS:    rd_byte = snap.status;
			`RSA_ADDR_OBSERVE:   rd_byte = snap.observe;
			`RSA_ADDR_CARRIER:   rd_byte = snap.carrier;
			`RSA_ADDR_P0:        rd_byte = (sh_r.byte_cnt <= `RSA_ADDR_BYTES) ?
			                               snap.p0[(sh_r.byte_cnt - 3'h1)*8 +: 8] : 8'h00;
			`RSA_ADDR_P1:        rd_byte = (sh_r.byte_cnt <= `RSA_ADDR_BYTES) ?
			                               snap.p1[(sh_r.byte_cnt - 3'h1)*8 +: 8] : 8'h00;
			`RSA_ADDR_P2:        rd_byte = snap.p2;
			`RSA_ADDR_P3:        rd_byte = snap.p3;
			`RSA_ADDR_P4:        rd_byte = snap.p4;
			`RSA_ADDR_P5:        rd_byte = snap.p5;
			default:             rd_byte = 8'h00;
		endcase
		if (fr_r.cmd[`RSA_CMD_OP_MSB:`RSA_CMD_OP_LSB] != `RSA_CMD_OP_READ) begin
			rd_byte = 8'h00;
		end
		if (sh_r.byte_cnt > 3'h1 && fr_r.cmd[`RSA_CMD_ADDR_MSB:0] != `RSA_ADDR_P0
		    && fr_r.cmd[`RSA_CMD_ADDR_MSB:0] != `RSA_ADDR_P1) begin
			rd_byte = 8'h00;
		end
	end

	assign out_byte = (sh_r.byte_cnt == 3'h0) ? snap.status : rd_byte;
	assign miso     = out_byte[~sh_r.bit_cnt];
	assign miso_oe  = ~cs_n;

endmodule

// File: logic/rsa_regs.sv
// Status, transmit observe, carrier detect and receive pipe address registers
`include "rsa_map.svh"

// Contract
// - Status byte shifts out during command byte
// - Receive ready sets on payload, write-1 clears
// - Sent flag sets on acknowledge when auto-ack is enabled, otherwise on send
// - Retransmit limit flag blocks until cleared
// - Status bits 3:1 report pipe, 111 empty
// - Status bit 0 shows transmit FIFO full
// - Lost packet count saturates at fifteen
// - Channel register write zeroes lost count
// - Retransmit count restarts per new packet
// - Carrier detect in bit 0, rest zero
// - Pipes 0,1 take LSByte-first width bytes
// - Pipes 2-5 borrow upper bytes from pipe 1
// - Pipe 2-5 low bytes reset C3..C6
// - Width code 01/10/11 gives 3/4/5 bytes
module rsa_regs (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 sck,
	input  wire logic                 cs_n,
	input  wire logic                 mosi,
	output logic                      miso,
	output logic                      miso_oe,
	input  wire rsa_pkg::rsa_events_t ev,
	output rsa_pkg::rsa_addr_out_t    addr_out,
	output logic                      comm_blocked
);
	import rsa_pkg::*;

	rsa_state_t s_r;
	rsa_state_t s_nxt;
	rsa_frame_t frame;
	logic       frame_end;
	logic       wr;
	logic [4:0] wr_addr;
	logic [2:0] n_bytes;
	logic [4:0] byte_ok;
	logic [7:0] b0;
	logic [3:0] lost_base;
	logic [3:0] retr_base;
	logic       sent_evt;

	// ----------------------------------------
	// Serial link on its own clock
	// ----------------------------------------
	rsa_spi_link u_link (
		.rst     (rst),
		.sck     (sck),
		.cs_n    (cs_n),
		.mosi    (mosi),
		.snap    (s_r.snap),
		.miso    (miso),
		.miso_oe (miso_oe),
		.frame   (frame)
	);

	// ----------------------------------------
	// Frame end and write decode
	// ----------------------------------------
	assign frame_end = s_r.cs_s2 & ~s_r.cs_s3;
	assign wr_addr   = frame.cmd[`RSA_CMD_ADDR_MSB:0];
	assign wr        = frame_end & frame.cmd_done & (|frame.byte_valid)
	                   & (frame.cmd[`RSA_CMD_OP_MSB:`RSA_CMD_OP_LSB] == `RSA_CMD_OP_WRITE);
	assign n_bytes   = {1'b0, s_r.width_code} + 3'h2;
	assign b0        = frame.data[7:0];

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			byte_ok[i] = frame.byte_valid[i] & (3'(i) < n_bytes);
		end
	end

	assign sent_evt = ev.auto_ack_enabled ? ev.ack_received : ev.packet_sent;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt       = s_r;
		s_nxt.cs_s1 = cs_n;
		s_nxt.cs_s2 = s_r.cs_s1;
		s_nxt.cs_s3 = s_r.cs_s2;

		// Flags: hardware set beats write-1 clear
		s_nxt.receive_ready_flag = (s_r.receive_ready_flag
			& ~(wr && wr_addr == `RSA_ADDR_STATUS && frame.byte_valid[0]
			&& b0[`RSA_ST_RX_READY])) | ev.rx_payload_arrived;
		s_nxt.transmit_sent_flag = (s_r.transmit_sent_flag
			& ~(wr && wr_addr == `RSA_ADDR_STATUS && frame.byte_valid[0]
			&& b0[`RSA_ST_TX_SENT])) | sent_evt;
		s_nxt.retransmit_limit_flag = (s_r.retransmit_limit_flag
			& ~(wr && wr_addr == `RSA_ADDR_STATUS && frame.byte_valid[0]
			&& b0[`RSA_ST_RT_LIMIT])) | ev.retransmit_limit_hit;

		// Read-only levels sampled from the datapath
		s_nxt.pipe_no        = ev.rx_pipe_index;
		s_nxt.tx_full        = ev.tx_fifo_full;
		s_nxt.carrier_detect = ev.carrier_sensed;

		// Lost packet counter
		lost_base = (wr && wr_addr == `RSA_ADDR_CHANNEL) ? 4'h0 : s_r.lost_packet_count;
		s_nxt.lost_packet_count = lost_base;
		if (ev.packet_lost && lost_base != `RSA_CNT_MAX) begin
			s_nxt.lost_packet_count = lost_base + 4'h1;
		end

		// Retransmit counter
		retr_base = ev.new_packet_start ? 4'h0 : s_r.retransmit_count;
		s_nxt.retransmit_count = retr_base;
		if (ev.packet_retransmitted && retr_base != `RSA_CNT_MAX) begin
			s_nxt.retransmit_count = retr_base + 4'h1;
		end

		// Register writes at frame end
		if (wr) begin
			case (wr_addr)
				`RSA_ADDR_WIDTH_SET: begin
					if (frame.byte_valid[0] && b0[1:0] != `RSA_WIDTH_ILLEGAL) begin
						s_nxt.width_code = b0[1:0];
					end
				end
				`RSA_ADDR_P0: begin
					for (int i = 0; i < 5; i++) begin
						if (byte_ok[i]) begin
							s_nxt.p0[i*8 +: 8] = frame.data[i*8 +: 8];
						end
					end
				end
				`RSA_ADDR_P1: begin
					for (int i = 0; i < 5; i++) begin
						if (byte_ok[i]) begin
							s_nxt.p1[i*8 +: 8] = frame.data[i*8 +: 8];
						end
					end
				end
				`RSA_ADDR_P2: begin
					if (frame.byte_valid[0]) begin
						s_nxt.p2 = b0;
					end
				end
				`RSA_ADDR_P3: begin
					if (frame.byte_valid[0]) begin
						s_nxt.p3 = b0;
					end
				end
				`RSA_ADDR_P4: begin
					if (frame.byte_valid[0]) begin
						s_nxt.p4 = b0;
					end
				end
				`RSA_ADDR_P5: begin
					if (frame.byte_valid[0]) begin
						s_nxt.p5 = b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Snapshot refreshed only while no frame runs
		if (s_r.cs_s2 && s_r.cs_s3) begin
			s_nxt.snap.status = {1'b0, s_r.receive_ready_flag, s_r.transmit_sent_flag,
			                     s_r.retransmit_limit_flag, s_r.pipe_no, s_r.tx_full};
			s_nxt.snap.observe = {s_r.lost_packet_count, s_r.retransmit_count};
			s_nxt.snap.carrier = {7'h00, s_r.carrier_detect};
			s_nxt.snap.p0      = s_r.p0;
			s_nxt.snap.p1      = s_r.p1;
			s_nxt.snap.p2      = s_r.p2;
			s_nxt.snap.p3      = s_r.p3;
			s_nxt.snap.p4      = s_r.p4;
			s_nxt.snap.p5      = s_r.p5;
			s_nxt.snap.width   = s_r.width_code;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r                   <= '0;
			s_r.cs_s1             <= 1'b1;
			s_r.cs_s2             <= 1'b1;
			s_r.cs_s3             <= 1'b1;
			s_r.pipe_no           <= `RSA_RST_PIPE_NO;
			s_r.width_code        <= `RSA_RST_WIDTH;
			s_r.p0                <= `RSA_RST_P0;
			s_r.p1                <= `RSA_RST_P1;
			s_r.p2                <= `RSA_RST_P2;
			s_r.p3                <= `RSA_RST_P3;
			s_r.p4                <= `RSA_RST_P4;
			s_r.p5                <= `RSA_RST_P5;
			s_r.snap.status       <= {4'h0, `RSA_RST_PIPE_NO, 1'b0};
			s_r.snap.p0           <= `RSA_RST_P0;
			s_r.snap.p1           <= `RSA_RST_P1;
			s_r.snap.p2           <= `RSA_RST_P2;
			s_r.snap.p3           <= `RSA_RST_P3;
			s_r.snap.p4           <= `RSA_RST_P4;
			s_r.snap.p5           <= `RSA_RST_P5;
			s_r.snap.width        <= `RSA_RST_WIDTH;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs to the datapath
	// ----------------------------------------
	assign addr_out.pipe_addr[0] = s_r.p0;
	assign addr_out.pipe_addr[1] = s_r.p1;
	assign addr_out.pipe_addr[2] = {s_r.p1[39:8], s_r.p2};
	assign addr_out.pipe_addr[3] = {s_r.p1[39:8], s_r.p3};
	assign addr_out.pipe_addr[4] = {s_r.p1[39:8], s_r.p4};
	assign addr_out.pipe_addr[5] = {s_r.p1[39:8], s_r.p5};
	assign addr_out.width_code   = s_r.width_code;
	assign comm_blocked          = s_r.retransmit_limit_flag;

endmodule

// File: tb/rsa_regs_sva.sv
// Checker for the register block ports
module rsa_regs_sva (
	input wire logic                 clk_sys,
	input wire logic                 rst,
	input wire logic                 sck,
	input wire logic                 cs_n,
	input wire logic                 mosi,
	input wire logic                 miso,
	input wire logic                 miso_oe,
	input wire rsa_pkg::rsa_events_t ev,
	input wire rsa_pkg::rsa_addr_out_t addr_out,
	input wire logic                 comm_blocked
);
	timeunit 1ns;
	timeprecision 1ps;
	import rsa_pkg::*;
	// ----------------------------------------
	// Idle cycles since the last frame
	// ----------------------------------------
	logic [3:0] hi_cnt_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			hi_cnt_r <= 4'hF;
		else if (!cs_n)
			hi_cnt_r <= 4'h0;
		else if (hi_cnt_r != 4'hF)
			hi_cnt_r <= hi_cnt_r + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_oe_follow: assert property (miso_oe == !cs_n)
		else $error("miso_oe does not follow chip select");
	chk_limit_sets: assert property (ev.retransmit_limit_hit |-> ##[1:2] comm_blocked)
		else $error("limit event did not block");
	chk_block_rise: assert property ($rose(comm_blocked) |->
		$past(ev.retransmit_limit_hit) || $past(ev.retransmit_limit_hit, 2))
		else $error("block rose without limit event");
	chk_block_hold: assert property (comm_blocked && hi_cnt_r == 4'hF |=> comm_blocked)
		else $error("block dropped without a write");
	chk_block_clear: assert property ($fell(comm_blocked) |-> hi_cnt_r inside {[1:7]})
		else $error("block cleared away from a frame");
	chk_pipe_upper: assert property (addr_out.pipe_addr[2][39:8] == addr_out.pipe_addr[1][39:8]
		&& addr_out.pipe_addr[5][39:8] == addr_out.pipe_addr[1][39:8])
		else $error("pipe upper bytes differ from pipe 1");
	chk_width_legal: assert property (addr_out.width_code != 2'h0)
		else $error("illegal width code stored");
	chk_addr_quiet: assert property ($changed(addr_out) |-> hi_cnt_r inside {[1:7]})
		else $error("address changed away from a frame");
	chk_one_target: assert property ($changed(addr_out.pipe_addr[0])
		|-> $stable(addr_out.pipe_addr[1]))
		else $error("one frame changed two pipes");
	cov_block: cover property ($rose(comm_blocked));
	cov_unblock: cover property ($fell(comm_blocked));
	cov_p0: cover property ($changed(addr_out.pipe_addr[0]));
endmodule

bind rsa_regs rsa_regs_sva chk (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n),
	.mosi(mosi), .miso(miso), .miso_oe(miso_oe), .ev(ev), .addr_out(addr_out),
	.comm_blocked(comm_blocked));

// File: tb/rsa_host.sv
// Host model driving the serial link
module rsa_host (
	output logic     sck,
	output logic     cs_n,
	output logic     mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// ----------------------------------------
	// One frame: command then n bytes
	// ----------------------------------------
	task automatic xfer(input logic [7:0] cmd, input int n, input logic [39:0] wd,
		output logic [7:0] st, output logic [39:0] rd);
		logic [47:0] tx;
		logic [47:0] rx;
		tx = {wd, cmd};
		rx = '0;
		cs_n = 1'b0;
		#160;
		for (int b = 0; b <= n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				mosi = tx[8*b+i];
				#6;
				rx[8*b+i] = miso;
				sck = 1'b1;
				#6;
				sck = 1'b0;
			end
		end
		#6;
		cs_n = 1'b1;
		mosi = ~mosi;
		st = rx[7:0];
		rd = rx[47:8];
		#400;
	endtask
endmodule

// File: tb/tb_rsa_regs.sv
// Testbench for the register block
module tb_rsa_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import rsa_pkg::*;
	logic          clk_sys;
	logic          rst;
	logic          sck;
	logic          cs_n;
	logic          mosi;
	logic          miso;
	logic          miso_oe;
	logic          comm_blocked;
	rsa_events_t   ev;
	rsa_addr_out_t addr_out;
	int            miscompares;
	int            comparisons;
	logic [7:0]    st;
	logic [39:0]   rd;
	logic [39:0]   prev;
	logic [39:0]   d;
	logic [39:0]   m;
	rsa_regs dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .ev(ev), .addr_out(addr_out),
		.comm_blocked(comm_blocked));
	rsa_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rd_reg(input logic [4:0] a, input int n);
		host.xfer({3'h0, a}, n, 40'h0, st, rd);
	endtask
	task automatic wr_reg(input logic [4:0] a, input int n, input logic [39:0] v);
		logic [39:0] x;
		host.xfer({3'h1, a}, n, v, st, x);
	endtask
	task automatic pulse(input int b, input int k);
		repeat (k) begin
			@(negedge clk_sys) ev[b] = 1'b1;
			@(negedge clk_sys) ev[b] = 1'b0;
		end
		repeat (16) @(negedge clk_sys);
	endtask
	initial begin
		#1000000;
		miscompares++;
		give_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		ev = '0;
		ev.rx_pipe_index = 3'h7;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		rd_reg(5'h07, 1);
		check(st, 8'h0E);
		check(rd[7:0], 8'h0E);
		rd_reg(5'h0A, 5);
		check(rd, 40'hE7E7E7E7E7);
		rd_reg(5'h0B, 5);
		check(rd, 40'hC2C2C2C2C2);
		for (int i = 0; i < 4; i++) begin
			rd_reg(5'h0C + 5'(i), 1);
			check(rd[7:0], 8'hC3 + 8'(i));
		end
		check(addr_out.pipe_addr[3], 40'hC2C2C2C2C4);
		rd_reg(5'h1F, 1);
		check(rd[7:0], 8'h00);
		@(negedge clk_sys);
		ev.tx_fifo_full = 1'b1;
		ev.rx_pipe_index = 3'h5;
		pulse(12, 1);
		pulse(7, 1);
		pulse(4, 1);
		rd_reg(5'h07, 1);
		check(st, 8'h7B);
		check(comm_blocked, 1'b1);
		wr_reg(5'h07, 1, 40'h0F);
		rd_reg(5'h07, 1);
		check(st, 8'h7B);
		wr_reg(5'h07, 1, 40'h70);
		rd_reg(5'h07, 1);
		check(st, 8'h0B);
		check(comm_blocked, 1'b0);
		@(negedge clk_sys);
		ev.auto_ack_enabled = 1'b1;
		pulse(7, 1);
		rd_reg(5'h07, 1);
		check(st, 8'h0B);
		pulse(6, 1);
		rd_reg(5'h07, 1);
		check(st, 8'h2B);
		wr_reg(5'h07, 1, 40'h20);
		for (int p = 0; p < 8; p++) begin
			@(negedge clk_sys);
			ev.rx_pipe_index = 3'(p);
			ev.tx_fifo_full = 1'b0;
			repeat (4) @(negedge clk_sys);
			rd_reg(5'h07, 1);
			check(st, {4'h0, 3'(p), 1'b0});
		end
		pulse(3, 16);
		rd_reg(5'h08, 1);
		check(rd[7:4], 4'hF);
		pulse(3, 1);
		rd_reg(5'h08, 1);
		check(rd[7:4], 4'hF);
		wr_reg(5'h05, 1, 40'h02);
		rd_reg(5'h08, 1);
		check(rd[7:4], 4'h0);
		pulse(2, 3);
		rd_reg(5'h08, 1);
		check(rd[3:0], 4'h3);
		pulse(1, 1);
		wr_reg(5'h08, 1, 40'hFF);
		rd_reg(5'h08, 1);
		check(rd[7:0], 8'h00);
		@(negedge clk_sys);
		ev.carrier_sensed = 1'b1;
		repeat (4) @(negedge clk_sys);
		rd_reg(5'h09, 1);
		check(rd[7:0], 8'h01);
		prev = 40'hE7E7E7E7E7;
		for (int w = 1; w < 4; w++) begin
			wr_reg(5'h03, 1, 40'(w));
			d = 40'h0101010101 * 40'(w);
			m = (40'h1 << (8 * (w + 2))) - 40'h1;
			prev = (prev & ~m) | (d & m);
			wr_reg(5'h0A, 5, d);
			rd_reg(5'h0A, 5);
			check(rd, prev);
			check(addr_out.pipe_addr[0], prev);
		end
		wr_reg(5'h03, 1, 40'h00);
		rd_reg(5'h03, 1);
		check(rd[7:0], 8'h03);
		check(addr_out.width_code, 2'h3);
		check(miso_oe, 1'b0);
		wr_reg(5'h0B, 5, 40'hAABBCCDDEE);
		check(addr_out.pipe_addr[5], 40'hAABBCCDDC6);
		wr_reg(5'h0C, 2, 40'h995A);
		check(addr_out.pipe_addr[2], 40'hAABBCCDD5A);
		check(addr_out.pipe_addr[1], 40'hAABBCCDDEE);
		check(addr_out.pipe_addr[4], 40'hAABBCCDDC5);
		give_verdict();
	end
endmodule
